// >>> src/tca_pkg.sv
// tca_pkg: register indices, field positions, codes and state record of
// the four-channel timer with pulse accumulator.
// assumes a 32-bit classic wishbone slave, one register per aligned word.
package tca_pkg;
    localparam int CH_N = 4;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_DIR = 6'h00;
    localparam logic [5:0] IDX_FORCE = 6'h01;
    localparam logic [5:0] IDX_C7MASK = 6'h02;
    localparam logic [5:0] IDX_C7DATA = 6'h03;
    localparam logic [5:0] IDX_TCNT = 6'h04;
    localparam logic [5:0] IDX_SYS = 6'h06;
    localparam logic [5:0] IDX_OUTCTL = 6'h08;
    localparam logic [5:0] IDX_EDGE = 6'h0a;
    localparam logic [5:0] IDX_IE = 6'h0c;
    localparam logic [5:0] IDX_SYS2 = 6'h0d;
    localparam logic [5:0] IDX_CFLG = 6'h0e;
    localparam logic [5:0] IDX_TFLG = 6'h0f;
    localparam logic [5:0] IDX_CVAL0 = 6'h18;
    localparam logic [5:0] IDX_CVAL3 = 6'h1b;
    localparam logic [5:0] IDX_ACTL = 6'h20;
    localparam logic [5:0] IDX_AFLG = 6'h21;
    localparam logic [5:0] IDX_ACNT = 6'h22;
    localparam logic [5:0] IDX_PORT = 6'h30;
    // field positions
    localparam int SYS_ON_BIT = 7;
    localparam int SYS_FFC_BIT = 4;
    localparam int SYS2_TOIE_BIT = 7;
    localparam int SYS2_COUNTER_RESET_ON_MATCH_BIT = 3;
    localparam int ACTL_ON_BIT = 6;
    localparam int ACTL_MODE_BIT = 5;
    localparam int ACTL_EDGE_BIT = 4;
    localparam int ACTL_CLK_LO = 2;
    localparam int ACTL_OVFIE_BIT = 1;
    localparam int ACTL_INIE_BIT = 0;
    localparam int AFLG_OVF_BIT = 1;
    localparam int AFLG_EDGE_BIT = 0;
    localparam int TFLG_TOF_BIT = 7;
    localparam int PORT_DIR_LO = 4;
    localparam int CH7 = 3;
    // counter clock select codes
    localparam logic [1:0] CLK_PRESC = 2'h0;
    localparam logic [1:0] CLK_ACC = 2'h1;
    localparam logic [1:0] CLK_ACC256 = 2'h2;
    localparam logic [1:0] CLK_ACC64K = 2'h3;
    // compare output actions, {mode, level}
    localparam logic [1:0] ACT_OFF = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;
    // divider terminal values
    localparam logic [5:0] DIV64_LAST = 6'h3f;
    localparam logic [7:0] DIV256_LAST = 8'hff;
    localparam logic [15:0] DIV64K_LAST = 16'hffff;
    localparam logic [15:0] CNT_LAST = 16'hffff;
    localparam logic [15:0] CNT_ZERO = 16'h0000;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic timer_on;
        logic fast_flag_clear;
        logic toie;
        logic counter_reset_on_match;
        logic [2:0] prescale_sel;
        logic accum_on;
        logic accum_mode_sel;
        logic accum_edge_sel;
        logic [1:0] clk_sel;
        logic accum_overflow_irq_on;
        logic accum_input_irq_on;
        logic accum_overflow_flag;
        logic accum_edge_flag;
        logic [15:0] accum_count;
        logic [15:0] ext_div;
        logic [6:0] presc;
        logic [15:0] tcnt;
        logic tof;
        logic [3:0] chan_direction_bit;
        logic [3:0] out_mode_bit;
        logic [3:0] out_level_bit;
        logic [7:0] cap_edge;
        logic [3:0] chan_irq_on;
        logic [3:0] chan_flag;
        logic [3:0] c7_mask;
        logic [3:0] c7_data;
        logic [3:0][15:0] chan_value;
        logic [3:0] port_latch;
        logic [3:0] port_dir;
        logic [3:0] cmp_level;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] prev;
        logic [3:0] pin_out;
        logic [3:0] pin_oe;
        logic [3:0] chan_irq;
        logic tof_irq;
        logic aovf_irq;
        logic aedge_irq;
    } tca_state_s;
endpackage : tca_pkg

// >>> src/tca_timer.sv
// tca_timer: 16-bit free-running counter, prescaler, four capture/compare
// channels and a 16-bit pulse accumulator on the last channel's pin.
// assumes pins synchronous to sys_clk and a classic wishbone master.
//
// Notes on behaviour
// R01 - select field picks counter clock source
// R02 - accumulator off forces prescaler clock
// R03 - clock select change takes effect immediately
// R04 - divide-by-64 exists only while timer on
// R05 - fast clear: count access clears accumulator flags
// R06 - overflow flag on wrap, write-one clears
// R07 - edge flag: event edge or gate trailing
// R08 - write one clears edge flag
// R09 - software accesses count as one word
// R10 - accumulator input synchronised before counting
// R11 - prescaler divides bus clock by powers
// R12 - capture copies counter, sets channel flag
// R13 - compare match drives pin, sets flag
// R14 - mode and level zero disconnect pin
// R15 - force performs compare action, no flag
// R16 - channel 7 match overrides masked pins
// R17 - channel 7 match may reset counter
// R18 - port write latched while pin compares
// R19 - event mode counts selected pin edges
// R20 - event counting ignores timer enable
// R21 - gated mode counts div64 while active
// R22 - irq enables gate accumulator flags out
// R23 - accumulator enable independent of timer
`timescale 1ns/1ps
module tca_timer (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [tca_pkg::CH_N-1:0] chan_pin_i,
    output logic [tca_pkg::CH_N-1:0] chan_pin_o,
    output logic [tca_pkg::CH_N-1:0] chan_pin_oe,
    output logic [tca_pkg::CH_N-1:0] chan_irq_o,
    output logic timer_ovf_irq_o,
    output logic accum_ovf_irq_o,
    output logic accum_edge_irq_o
);
    import tca_pkg::*;

    tca_state_s st_r;
    tca_state_s st_nxt;
    logic acc;
    logic wr;
    logic [5:0] idx;
    logic [6:0] pmask;
    logic pre_tick;
    logic div64_tick;
    logic pin7;
    logic prev7;
    logic act_lvl;
    logic acc_edge;
    logic gate_end;
    logic accum_clock;
    logic ext_tick;
    logic cnt_tick;
    logic [15:0] cnt_n;
    logic [3:0] rise;
    logic [3:0] fall;
    logic [3:0] capt;
    logic [3:0] match;
    logic [3:0] force_w;
    logic [1:0] act;
    logic [31:0] rd;

    // whole next state in one pass; set terms follow clears so sets win
    always_comb begin
        st_nxt = st_r;
        acc = wb_cyc_i & wb_stb_i & ~st_r.ack;
        wr = acc & wb_we_i;
        idx = wb_adr_i[7:2];
        rd = 32'h0;
        act = ACT_OFF;
        force_w = 4'h0;

        // prescaler: free count, tick when low bits all ones
        pmask = 7'((8'h01 << st_r.prescale_sel) - 8'h01); // R11
        pre_tick = st_r.timer_on && ((st_r.presc & pmask) == pmask); // R11
        div64_tick = st_r.timer_on && (st_r.presc[5:0] == DIV64_LAST); // R04
        st_nxt.presc = st_r.timer_on ? st_r.presc + 7'h01 : 7'h00;

        // pin edges come from the second sync stage only
        rise = st_r.sync2 & ~st_r.prev; // R10
        fall = ~st_r.sync2 & st_r.prev; // R10
        st_nxt.sync1 = chan_pin_i;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.prev = st_r.sync2;

        // accumulator input: edge bit picks polarity in both modes
        pin7 = st_r.sync2[CH7];
        prev7 = st_r.prev[CH7];
        act_lvl = st_r.accum_edge_sel ? ~pin7 : pin7; // R21
        acc_edge = st_r.accum_edge_sel ? rise[CH7] : fall[CH7]; // R19
        // trailing edge of active gate is the edge leaving active level
        gate_end = st_r.accum_edge_sel ? rise[CH7] : fall[CH7]; // R07
        if (!st_r.accum_on) begin
            accum_clock = 1'b0; // R23
        end else if (!st_r.accum_mode_sel) begin
            accum_clock = acc_edge; // R19 R20
        end else begin
            accum_clock = div64_tick && act_lvl; // R21 R04
        end

        // external divider for the slow counter clock choices
        if (accum_clock) begin
            st_nxt.ext_div = st_r.ext_div + 16'h0001;
        end
        if (st_r.clk_sel == CLK_ACC256) begin
            ext_tick = accum_clock && (st_r.ext_div[7:0] == DIV256_LAST); // R01
        end else begin
            ext_tick = accum_clock && (st_r.ext_div == DIV64K_LAST); // R01
        end

        // counter clock mux, read live from the select field
        if (!st_r.accum_on || st_r.clk_sel == CLK_PRESC) begin
            cnt_tick = pre_tick; // R02 R01 R03
        end else if (st_r.clk_sel == CLK_ACC) begin
            cnt_tick = st_r.timer_on && accum_clock; // R01 R03
        end else begin
            cnt_tick = st_r.timer_on && ext_tick; // R01 R03
        end

        // free-running counter; channel 7 match may restart it
        cnt_n = st_r.tcnt;
        if (cnt_tick) begin
            if (st_r.counter_reset_on_match && st_r.chan_direction_bit[CH7]
                && st_r.tcnt == st_r.chan_value[CH7]) begin
                cnt_n = CNT_ZERO; // R17
            end else begin
                cnt_n = st_r.tcnt + 16'h0001;
            end
        end
        st_nxt.tcnt = cnt_n;

        // register writes; flags are write-one-to-clear
        if (wr && idx == IDX_DIR && wb_sel_i[0]) begin
            st_nxt.chan_direction_bit = wb_dat_i[3:0];
        end
        if (wr && idx == IDX_FORCE && wb_sel_i[0]) begin
            force_w = wb_dat_i[3:0]; // R15
        end
        if (wr && idx == IDX_C7MASK && wb_sel_i[0]) begin
            st_nxt.c7_mask = wb_dat_i[3:0];
        end
        if (wr && idx == IDX_C7DATA && wb_sel_i[0]) begin
            st_nxt.c7_data = wb_dat_i[3:0];
        end
        if (wr && idx == IDX_SYS && wb_sel_i[0]) begin
            st_nxt.timer_on = wb_dat_i[SYS_ON_BIT];
            st_nxt.fast_flag_clear = wb_dat_i[SYS_FFC_BIT];
        end
        if (wr && idx == IDX_OUTCTL && wb_sel_i[0]) begin
            for (int k = 0; k < CH_N; k++) begin
                st_nxt.out_mode_bit[k] = wb_dat_i[2*k+1];
                st_nxt.out_level_bit[k] = wb_dat_i[2*k];
            end
        end
        if (wr && idx == IDX_EDGE && wb_sel_i[0]) begin
            st_nxt.cap_edge = wb_dat_i[7:0];
        end
        if (wr && idx == IDX_IE && wb_sel_i[0]) begin
            st_nxt.chan_irq_on = wb_dat_i[3:0];
        end
        if (wr && idx == IDX_SYS2 && wb_sel_i[0]) begin
            st_nxt.toie = wb_dat_i[SYS2_TOIE_BIT];
            st_nxt.counter_reset_on_match = wb_dat_i[SYS2_COUNTER_RESET_ON_MATCH_BIT];
            st_nxt.prescale_sel = wb_dat_i[2:0]; // R11
        end
        if (wr && idx == IDX_CFLG && wb_sel_i[0]) begin
            st_nxt.chan_flag = st_r.chan_flag & ~wb_dat_i[3:0];
        end
        if (wr && idx == IDX_TFLG && wb_sel_i[0]
            && wb_dat_i[TFLG_TOF_BIT]) begin
            st_nxt.tof = 1'b0;
        end
        // any counter access clears the overflow flag under fast clear
        if (acc && idx == IDX_TCNT && st_r.fast_flag_clear) begin
            st_nxt.tof = 1'b0;
        end
        if (wr && idx == IDX_ACTL && wb_sel_i[0]) begin
            st_nxt.accum_on = wb_dat_i[ACTL_ON_BIT];
            st_nxt.accum_mode_sel = wb_dat_i[ACTL_MODE_BIT];
            st_nxt.accum_edge_sel = wb_dat_i[ACTL_EDGE_BIT];
            st_nxt.clk_sel = wb_dat_i[ACTL_CLK_LO+1:ACTL_CLK_LO]; // R03
            st_nxt.accum_overflow_irq_on = wb_dat_i[ACTL_OVFIE_BIT];
            st_nxt.accum_input_irq_on = wb_dat_i[ACTL_INIE_BIT];
        end
        if (wr && idx == IDX_AFLG && wb_sel_i[0]) begin
            if (wb_dat_i[AFLG_OVF_BIT]) begin
                st_nxt.accum_overflow_flag = 1'b0; // R06
            end
            if (wb_dat_i[AFLG_EDGE_BIT]) begin
                st_nxt.accum_edge_flag = 1'b0; // R08
            end
        end
        if (acc && idx == IDX_ACNT && st_r.fast_flag_clear) begin
            st_nxt.accum_overflow_flag = 1'b0; // R05
            st_nxt.accum_edge_flag = 1'b0; // R05
        end
        if (wr && idx == IDX_PORT && wb_sel_i[0]) begin
            st_nxt.port_latch = wb_dat_i[3:0]; // R18
            st_nxt.port_dir = wb_dat_i[PORT_DIR_LO+3:PORT_DIR_LO];
        end

        // pulse accumulator count; a same-cycle bus write takes priority
        if (accum_clock) begin
            st_nxt.accum_count = st_r.accum_count + 16'h0001; // R19 R21
            if (st_r.accum_count == CNT_LAST) begin
                st_nxt.accum_overflow_flag = 1'b1; // R06
            end
        end
        if (wr && idx == IDX_ACNT) begin
            if (wb_sel_i[0]) begin
                st_nxt.accum_count[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                st_nxt.accum_count[15:8] = wb_dat_i[15:8];
            end
        end
        if (st_r.accum_on) begin
            if (!st_r.accum_mode_sel ? acc_edge : gate_end) begin
                st_nxt.accum_edge_flag = 1'b1; // R07
            end
        end
        if (cnt_tick && st_r.tcnt == CNT_LAST) begin
            st_nxt.tof = 1'b1;
        end

        // channels: capture, compare, force, then channel 7 override
        for (int k = 0; k < CH_N; k++) begin
            capt[k] = ~st_r.chan_direction_bit[k]
                      & ((st_r.cap_edge[2*k] & rise[k])
                      | (st_r.cap_edge[2*k+1] & fall[k]));
            match[k] = st_r.chan_direction_bit[k] & cnt_tick
                       & (cnt_n == st_r.chan_value[k]);
            if (capt[k]) begin
                st_nxt.chan_value[k] = st_r.tcnt; // R12
            end else if (wr && st_r.chan_direction_bit[k]
                         && idx == IDX_CVAL0 + 6'(k)) begin
                if (wb_sel_i[0]) begin
                    st_nxt.chan_value[k][7:0] = wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    st_nxt.chan_value[k][15:8] = wb_dat_i[15:8];
                end
            end
            if (capt[k] || match[k]) begin
                st_nxt.chan_flag[k] = 1'b1; // R12 R13
            end
            act = {st_r.out_mode_bit[k], st_r.out_level_bit[k]};
            if (match[k] || (force_w[k] && st_r.chan_direction_bit[k])) begin
                case (act) // R13 R15
                    ACT_TOGGLE: st_nxt.cmp_level[k] = ~st_r.cmp_level[k];
                    ACT_CLEAR: st_nxt.cmp_level[k] = 1'b0;
                    ACT_SET: st_nxt.cmp_level[k] = 1'b1;
                    default: st_nxt.cmp_level[k] = st_r.cmp_level[k];
                endcase
            end
        end
        for (int k = 0; k < CH_N; k++) begin
            if (st_r.c7_mask[k] && (match[CH7]
                || (force_w[CH7] && st_r.chan_direction_bit[CH7]))) begin
                st_nxt.cmp_level[k] = st_r.c7_data[k]; // R16
            end
            // pin connects to compare logic on an output channel unless mode and level are zero, and always when masked under output channel 7
            if ((st_r.chan_direction_bit[k]
                 && (st_r.out_mode_bit[k] || st_r.out_level_bit[k]))
                || (st_r.chan_direction_bit[CH7] && st_r.c7_mask[k])) begin
                st_nxt.pin_out[k] = st_nxt.cmp_level[k]; // R14 R18
                st_nxt.pin_oe[k] = 1'b1;
            end else begin
                st_nxt.pin_out[k] = st_r.port_latch[k]; // R14 R18
                st_nxt.pin_oe[k] = st_r.port_dir[k];
            end
        end

        // interrupt request levels
        st_nxt.chan_irq = st_nxt.chan_flag & st_nxt.chan_irq_on;
        st_nxt.tof_irq = st_nxt.tof & st_nxt.toie;
        st_nxt.aovf_irq = st_nxt.accum_overflow_flag
                          & st_nxt.accum_overflow_irq_on; // R22
        st_nxt.aedge_irq = st_nxt.accum_edge_flag
                           & st_nxt.accum_input_irq_on; // R22

        // read mux; whole count returned in one word, never split
        if (idx == IDX_DIR) begin
            rd[3:0] = st_r.chan_direction_bit;
        end else if (idx == IDX_C7MASK) begin
            rd[3:0] = st_r.c7_mask;
        end else if (idx == IDX_C7DATA) begin
            rd[3:0] = st_r.c7_data;
        end else if (idx == IDX_TCNT) begin
            rd[15:0] = st_r.tcnt;
        end else if (idx == IDX_SYS) begin
            rd[SYS_ON_BIT] = st_r.timer_on;
            rd[SYS_FFC_BIT] = st_r.fast_flag_clear;
        end else if (idx == IDX_OUTCTL) begin
            for (int k = 0; k < CH_N; k++) begin
                rd[2*k+1] = st_r.out_mode_bit[k];
                rd[2*k] = st_r.out_level_bit[k];
            end
        end else if (idx == IDX_EDGE) begin
            rd[7:0] = st_r.cap_edge;
        end else if (idx == IDX_IE) begin
            rd[3:0] = st_r.chan_irq_on;
        end else if (idx == IDX_SYS2) begin
            rd[SYS2_TOIE_BIT] = st_r.toie;
            rd[SYS2_COUNTER_RESET_ON_MATCH_BIT] = st_r.counter_reset_on_match;
            rd[2:0] = st_r.prescale_sel;
        end else if (idx == IDX_CFLG) begin
            rd[3:0] = st_r.chan_flag;
        end else if (idx == IDX_TFLG) begin
            rd[TFLG_TOF_BIT] = st_r.tof;
        end else if (idx >= IDX_CVAL0 && idx <= IDX_CVAL3) begin
            rd[15:0] = st_r.chan_value[2'(idx - IDX_CVAL0)];
        end else if (idx == IDX_ACTL) begin
            rd[ACTL_ON_BIT] = st_r.accum_on;
            rd[ACTL_MODE_BIT] = st_r.accum_mode_sel;
            rd[ACTL_EDGE_BIT] = st_r.accum_edge_sel;
            rd[ACTL_CLK_LO+1:ACTL_CLK_LO] = st_r.clk_sel;
            rd[ACTL_OVFIE_BIT] = st_r.accum_overflow_irq_on;
            rd[ACTL_INIE_BIT] = st_r.accum_input_irq_on;
        end else if (idx == IDX_AFLG) begin
            rd[AFLG_OVF_BIT] = st_r.accum_overflow_flag;
            rd[AFLG_EDGE_BIT] = st_r.accum_edge_flag;
        end else if (idx == IDX_ACNT) begin
            rd[15:0] = st_r.accum_count; // R09
        end else if (idx == IDX_PORT) begin
            rd[3:0] = st_r.port_latch;
            rd[PORT_DIR_LO+3:PORT_DIR_LO] = st_r.port_dir;
        end else begin
            rd = 32'h0; // unmapped: acked, reads zero
        end
        st_nxt.ack = acc;
        st_nxt.rdata = acc ? rd : 32'h0;
    end

    // single state register, constants only under reset
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state flops
    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.rdata;
    assign chan_pin_o = st_r.pin_out;
    assign chan_pin_oe = st_r.pin_oe;
    assign chan_irq_o = st_r.chan_irq;
    assign timer_ovf_irq_o = st_r.tof_irq;
    assign accum_ovf_irq_o = st_r.aovf_irq;
    assign accum_edge_irq_o = st_r.aedge_irq;
endmodule : tca_timer

// >>> verif/tca_pin_model.sv
// tca_pin_model: the outside world on the four channel pins.
// assumes ext_lvl holds what outside sources drive on each pin.
`timescale 1ns/1ps
module tca_pin_model (
    input wire logic [3:0] ext_lvl,
    input wire logic [3:0] drv_val,
    input wire logic [3:0] drv_en,
    output logic [3:0] pin_val
);
    // a driven pin reads back its own level; a released pin follows the
    // source, which the bench holds for at least three clocks, over the one-clock
    // minimum width
    assign pin_val = (drv_en & drv_val) | (~drv_en & ext_lvl);
endmodule : tca_pin_model

// >>> verif/tca_timer_chk.sv
// tca_timer_chk: bus handshake, flag clear and pin enable checks.
// assumes it is bound into every tca_timer instance.
`timescale 1ns/1ps
module tca_timer_chk (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [tca_pkg::CH_N-1:0] chan_pin_i,
    input wire logic [tca_pkg::CH_N-1:0] chan_pin_o,
    input wire logic [tca_pkg::CH_N-1:0] chan_pin_oe,
    input wire logic [tca_pkg::CH_N-1:0] chan_irq_o,
    input wire logic timer_ovf_irq_o,
    input wire logic accum_ovf_irq_o,
    input wire logic accum_edge_irq_o
);
    import tca_pkg::*;
    logic req;
    logic wr;
    logic afw;
    // a request counts only before its ack, so a held cycle is one request
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = req & wb_we_i;
    assign afw = wr & wb_sel_i[0] & (wb_adr_i[7:2] == IDX_AFLG);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    property p_ack_next; req |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("late ack");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
    property p_ack_cause; wb_ack_o |-> $past(req); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data not idle");
    property p_quiet;
        $rose(reset_n) |-> !wb_ack_o && chan_pin_oe == 4'h0
            && !accum_ovf_irq_o;
    endproperty
    a_quiet: assert property (p_quiet) else $error("busy after reset");
    property p_ovf_clr;
        afw && wb_dat_i[AFLG_OVF_BIT] |-> ##2 !accum_ovf_irq_o;
    endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("ovf kept");
    property p_edge_clr;
        afw && wb_dat_i[AFLG_EDGE_BIT] |-> ##2 !accum_edge_irq_o;
    endproperty
    a_edge_clr: assert property (p_edge_clr) else $error("edge kept");
    // pin enables follow configuration only, so only writes move them
    property p_oe_src;
        $changed(chan_pin_oe) |-> $past(wr) || $past(wr, 2);
    endproperty
    a_oe_src: assert property (p_oe_src) else $error("oe moved");
    c_aflg_wr: cover property (afw);
    c_edge_irq: cover property ($rose(accum_edge_irq_o));
    c_oe_on: cover property ($rose(chan_pin_oe[1]));
endmodule : tca_timer_chk

bind tca_timer tca_timer_chk i_tca_timer_chk (
    .sys_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .chan_pin_i, .chan_pin_o,
    .chan_pin_oe, .chan_irq_o, .timer_ovf_irq_o, .accum_ovf_irq_o,
    .accum_edge_irq_o
);

// >>> verif/tb_top.sv
// tb_top: wishbone register tests of the timer and its accumulator.
// assumes the pin model on the channel pins and the bound checker.
`timescale 1ns/1ps
module tb_top;
    import tca_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h3;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, v;
    logic wb_ack_o, timer_ovf_irq_o, accum_ovf_irq_o, accum_edge_irq_o;
    logic [3:0] lvl = 4'h0;
    logic [3:0] chan_pin_i, chan_pin_o, chan_pin_oe, chan_irq_o;
    logic [15:0] t0, dt;
    int miscompares = 0;
    int checks_done = 0;
    // 200 MHz bus clock
    always #2.5 sys_clk = ~sys_clk;
    tca_timer i_tca_timer (.sys_clk, .reset_n, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .chan_pin_i, .chan_pin_o, .chan_pin_oe, .chan_irq_o,
        .timer_ovf_irq_o, .accum_ovf_irq_o, .accum_edge_irq_o);
    tca_pin_model i_tca_pin_model (.ext_lvl(lvl), .drv_val(chan_pin_o),
        .drv_en(chan_pin_oe), .pin_val(chan_pin_i));
    // compares: exact value, then inclusive range
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic chkr(input logic [15:0] g, lo, hi);
        checks_done++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            miscompares++;
            $display("unexpected at %0t: %h outside range", $time, g);
        end
    endtask : chkr
    task automatic test_done;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    // one classic cycle; ack is looked at as sampled on each edge
    task automatic wbx(input logic w, input logic [5:0] a,
        input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {a, 2'h0};
        wb_dat_i <= d;
        do begin
            @(posedge sys_clk);
        end while (wb_ack_o !== 1'b1);
        v = wb_dat_o;
        chk({31'h0, wb_ack_o}, 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask : wbx
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        wbx(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [5:0] a);
        wbx(1'b0, a, 32'h0);
    endtask : rd
    task automatic rdc(input logic [5:0] a, input logic [31:0] e);
        rd(a);
        chk(v, e);
    endtask : rdc
    // full pulses on the shared channel pin
    task automatic pulse(input int n);
        repeat (n) begin
            lvl[3] <= 1'b1;
            repeat (4) @(posedge sys_clk);
            lvl[3] <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
    endtask : pulse
    task automatic span(input int n);
        rd(IDX_TCNT);
        t0 = v[15:0];
        repeat (n) @(posedge sys_clk);
        rd(IDX_TCNT);
        dt = v[15:0] - t0;
    endtask : span
    // main sequence
    initial begin
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        rdc(IDX_ACTL, 32'h0);
        rdc(6'h3f, 32'h0); // unmapped
        wr(IDX_ACTL, 32'h50);
        pulse(5);
        rdc(IDX_ACNT, 32'h5);
        rdc(IDX_AFLG, 32'h1);
        wr(IDX_ACTL, 32'h51);
        chk({31'h0, accum_edge_irq_o}, 32'h1);
        wr(IDX_AFLG, 32'h0);
        rdc(IDX_AFLG, 32'h1);
        wr(IDX_AFLG, 32'h1);
        rdc(IDX_AFLG, 32'h0);
        lvl[3] <= 1'b1;
        rdc(IDX_ACNT, 32'h5);
        lvl[3] <= 1'b0;
        rdc(IDX_ACNT, 32'h6);
        wr(IDX_SYS, 32'h10);
        rdc(IDX_AFLG, 32'h1);
        rdc(IDX_ACNT, 32'h6);
        rdc(IDX_AFLG, 32'h0);
        wr(IDX_SYS, 32'h0);
        wr(IDX_ACNT, 32'hffff);
        wr(IDX_ACTL, 32'h52);
        pulse(1);
        rdc(IDX_ACNT, 32'h0);
        rdc(IDX_AFLG, 32'h3);
        chk({31'h0, accum_ovf_irq_o}, 32'h1);
        wr(IDX_AFLG, 32'h2);
        rdc(IDX_AFLG, 32'h1);
        wr(IDX_AFLG, 32'h1);
        // gated: nothing while the timer is off, div64 pulses once on
        wr(IDX_ACTL, 32'h60);
        lvl[3] <= 1'b1;
        repeat (200) @(posedge sys_clk);
        lvl[3] <= 1'b0;
        rdc(IDX_ACNT, 32'h0);
        rdc(IDX_AFLG, 32'h1);
        wr(IDX_AFLG, 32'h1);
        wr(IDX_SYS, 32'h80);
        lvl[3] <= 1'b1;
        repeat (640) @(posedge sys_clk);
        lvl[3] <= 1'b0;
        rd(IDX_ACNT);
        chkr(v[15:0], 16'h9, 16'hb);
        // counter clock from the accumulator, by select code
        for (int k = 1; k < 4; k++) begin
            wr(IDX_ACTL, 32'h40 | 32'(k << 2));
            rd(IDX_TCNT);
            t0 = v[15:0];
            pulse(3);
            rd(IDX_TCNT);
            chk({16'h0, v[15:0] - t0}, (k == 1) ? 32'h3 : 32'h0);
        end
        wr(IDX_ACTL, 32'h04);
        span(0);
        chk({16'h0, dt}, 32'h3);
        for (int s = 0; s < 8; s++) begin
            wr(IDX_SYS2, 32'(s));
            span(253);
            chkr(dt, 16'((256 >> s) - 1), 16'((256 >> s) + 1));
        end
        // channel 1 compare, then channel 7 match over it
        wr(IDX_SYS2, 32'h0);
        wr(IDX_DIR, 32'h2);
        chk({31'h0, chan_pin_oe[1]}, 32'h0);
        wr(IDX_OUTCTL, 32'hc);
        chk({31'h0, chan_pin_oe[1]}, 32'h1);
        wr(IDX_FORCE, 32'h2);
        chk({31'h0, chan_pin_o[1]}, 32'h1);
        rdc(IDX_CFLG, 32'h0);
        wr(IDX_OUTCTL, 32'h8);
        rd(IDX_TCNT);
        wr(IDX_CVAL0 + 6'h1, {16'h0, v[15:0] + 16'h28});
        repeat (60) @(posedge sys_clk);
        chk({31'h0, chan_pin_o[1]}, 32'h0);
        rdc(IDX_CFLG, 32'h2);
        wr(IDX_IE, 32'h2);
        chk({28'h0, chan_irq_o}, 32'h2);
        wr(IDX_C7MASK, 32'h2);
        wr(IDX_C7DATA, 32'h2);
        wr(IDX_SYS2, 32'h8);
        wr(IDX_DIR, 32'ha);
        rd(IDX_TCNT);
        wr(IDX_CVAL3, {16'h0, v[15:0] + 16'h28});
        repeat (50) @(posedge sys_clk);
        chk({31'h0, chan_pin_o[1]}, 32'h1);
        rd(IDX_TCNT);
        chkr(v[15:0], 16'h0, 16'h20);
        test_done();
    end
    // watchdog, well past the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        test_done();
    end
endmodule : tb_top
